/* File: design/pin_sync3.sv */
// Three-stage synchroniser for asynchronous input levels.
// Assumes inputs are slow levels; output follows once stages two and three agree.
`default_nettype none

module pin_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] levelOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;
  wire [WIDTH-1:0] agree = ~(stage2_ff ^ stage3_ff);
  wire [WIDTH-1:0] nxt_level = (agree & stage3_ff) | (~agree & level_ff);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1_ff <= INIT;
      stage2_ff <= INIT;
      stage3_ff <= INIT;
      level_ff <= INIT;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff <= nxt_level;
    end
  end

  assign levelOut = level_ff;

endmodule

`default_nettype wire

/* File: design/pmic_mask_status_control_regs.sv */
// Switch interrupt mask, chip status and power control registers.
// Assumes a byte register port driven by the serial target logic on clk,
// and analog/pin inputs that are asynchronous to clk.
`default_nettype none

module pmic_mask_status_control_regs
  import pmic_regs_pkg::*;
#(
  parameter int SETTLE_CYCLES = CELL_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic mainsDetectPin_n,
  input wire logic buttonPin_n,
  input wire logic powerfailOutLow_n,
  input wire logic factorySeal,
  input wire logic nvmDefaultsChanged,
  input wire logic [1:0] seqState,
  input wire logic [2:0] swFaultActive,
  input wire logic [2:0] swLimiting,
  input wire logic cellAboveLow,
  input wire logic cellAboveGood,
  input wire logic cellAboveIdeal,
  output logic cellCompEnable,
  output logic backupCellMeasureDone,
  output logic [2:0] swFaultFlag,
  output logic [2:0] swIlimitFlag,
  output logic powerfailShutdownReq,
  output logic irqOutLow_n
);

  // Reset release through two flops
  logic rstMeta_ff;
  logic rstSync_ff;
  wire rstN = rstSync_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  // Pin and comparator synchronisers
  localparam int NUM_ASYNC = 14;
  // Pins idle high, all else low: no false event after reset
  localparam logic [NUM_ASYNC-1:0] ASYNC_INIT = 14'h3800;

  wire [NUM_ASYNC-1:0] asyncRaw = {
    powerfailOutLow_n,
    buttonPin_n,
    mainsDetectPin_n,
    factorySeal,
    nvmDefaultsChanged,
    swFaultActive,
    swLimiting,
    cellAboveLow,
    cellAboveGood,
    cellAboveIdeal
  };
  logic [NUM_ASYNC-1:0] asyncLevel;

  pin_sync3 #(
    .WIDTH(NUM_ASYNC),
    .INIT(ASYNC_INIT)
  ) u_pin_sync (
    .clk(clk),
    .rstN(rstN),
    .pinIn(asyncRaw),
    .levelOut(asyncLevel)
  );

  wire powerfailLow = ~asyncLevel[13];
  wire buttonLow = ~asyncLevel[12];
  wire mainsLow = ~asyncLevel[11];
  wire sealBroken = asyncLevel[10];
  wire nvmChanged = asyncLevel[9];
  wire [2:0] faultLevel = asyncLevel[8:6];
  wire [2:0] limitLevel = asyncLevel[5:3];
  wire aboveLow = asyncLevel[2];
  wire aboveGood = asyncLevel[1];
  wire aboveIdeal = asyncLevel[0];

  // Address decode
  wire selMask = (regAddr == ADDR_SWITCH_IRQ_MASK);
  wire selStatus = (regAddr == ADDR_CHIP_STATUS);
  wire selControl = (regAddr == ADDR_POWER_CONTROL);
  wire wrMask = regWrEn & selMask;
  wire wrControl = regWrEn & selControl;

  // Switch interrupt mask register
  logic [7:0] switchIrqMask_ff;
  wire [7:0] nxt_switchIrqMask = wrMask ? (regWrData & SWITCH_MASK_WMASK) : switchIrqMask_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      switchIrqMask_ff <= RST_SWITCH_IRQ_MASK;
    end else begin
      switchIrqMask_ff <= nxt_switchIrqMask;
    end
  end

  wire [2:0] faultMask = switchIrqMask_ff[FAULT_MASK_LSB +: NUM_SWITCHES];
  wire [2:0] ilimitMask = switchIrqMask_ff[ILIMIT_MASK_LSB +: NUM_SWITCHES];

  // Event flags run regardless of masks
  logic [2:0] faultFlag_ff;
  logic [2:0] ilimitFlag_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      faultFlag_ff <= '0;
      ilimitFlag_ff <= '0;
    end else begin
      faultFlag_ff <= faultLevel;
      ilimitFlag_ff <= limitLevel;
    end
  end

  assign swFaultFlag = faultFlag_ff;
  assign swIlimitFlag = ilimitFlag_ff;

  // Interrupt pin gating, per switch
  logic [2:0] faultPending;
  logic [2:0] ilimitPending;

  genvar sw;
  generate
    for (sw = 0; sw < NUM_SWITCHES; sw++) begin : g_gate
      assign faultPending[sw] = faultFlag_ff[sw] & ~faultMask[sw];
      assign ilimitPending[sw] = ilimitFlag_ff[sw] & ~ilimitMask[sw];
    end
  endgenerate

  // Flags stay visible under masks; only the pin is gated
  wire anyPending = |{faultPending, ilimitPending};
  // Registered so decode hazards never glitch the pin
  logic irqLow_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      irqLow_ff <= 1'b0;
    end else begin
      irqLow_ff <= anyPending;
    end
  end

  assign irqOutLow_n = ~irqLow_ff;

  // Power control register
  logic pfShutdownEn_ff;
  logic measureGo_ff;
  wire measureDoneNow;
  // Go while busy is refused, so a running count never restarts
  wire startMeasure = wrControl & regWrData[CTL_GO_BIT] & ~measureGo_ff;
  wire nxt_pfShutdownEn = wrControl ? regWrData[CTL_PFSHUT_BIT] : pfShutdownEn_ff;
  wire nxt_measureGo = startMeasure | (measureGo_ff & ~measureDoneNow);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pfShutdownEn_ff <= RST_POWER_CONTROL[CTL_PFSHUT_BIT];
      measureGo_ff <= RST_POWER_CONTROL[CTL_GO_BIT];
    end else begin
      pfShutdownEn_ff <= nxt_pfShutdownEn;
      measureGo_ff <= nxt_measureGo;
    end
  end

  // Power-fail shutdown request toward the sequencer
  logic pfShutdown_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      pfShutdown_ff <= 1'b0;
    end else begin
      pfShutdown_ff <= pfShutdownEn_ff & powerfailLow;
    end
  end

  assign powerfailShutdownReq = pfShutdown_ff;

  // Backup cell measurement sequencer
  // Comparators settle first; the level is taken once, at capture
  localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

  meas_state_t measState_ff;
  meas_state_t nxt_measState;
  logic [SETTLE_W-1:0] settleCnt_ff;
  logic [SETTLE_W-1:0] nxt_settleCnt;

  always_comb begin
    nxt_measState = measState_ff;
    nxt_settleCnt = settleCnt_ff;
    unique case (measState_ff)
      MEAS_IDLE: begin
        nxt_settleCnt = '0;
        if (startMeasure) begin
          nxt_measState = MEAS_SETTLE;
        end
      end
      MEAS_SETTLE: begin
        nxt_settleCnt = settleCnt_ff + SETTLE_W'(1);
        if (settleCnt_ff == SETTLE_LAST) begin
          nxt_measState = MEAS_CAPTURE;
        end
      end
      MEAS_CAPTURE: begin
        nxt_measState = MEAS_IDLE;
      end
      default: begin
        nxt_measState = MEAS_IDLE;
        nxt_settleCnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      measState_ff <= MEAS_IDLE;
      settleCnt_ff <= '0;
    end else begin
      measState_ff <= nxt_measState;
      settleCnt_ff <= nxt_settleCnt;
    end
  end

  assign measureDoneNow = (measState_ff == MEAS_CAPTURE);

  // Comparators powered only while measuring, to save coin-cell charge
  logic compEnable_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      compEnable_ff <= 1'b0;
    end else begin
      compEnable_ff <= (nxt_measState != MEAS_IDLE);
    end
  end

  assign cellCompEnable = compEnable_ff;

  // Threshold ladder to level code
  logic [1:0] cellCode;

  always_comb begin
    if (aboveIdeal) begin
      cellCode = CELL_IDEAL;
    end else if (aboveGood) begin
      cellCode = CELL_GOOD;
    end else if (aboveLow) begin
      cellCode = CELL_LOW;
    end else begin
      cellCode = CELL_ABSENT;
    end
  end

  // Level held until the next completed measurement
  logic [1:0] cellLevel_ff;
  logic measureDone_ff;
  wire [1:0] nxt_cellLevel = measureDoneNow ? cellCode : cellLevel_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cellLevel_ff <= CELL_ABSENT;
      measureDone_ff <= 1'b0;
    end else begin
      cellLevel_ff <= nxt_cellLevel;
      measureDone_ff <= measureDoneNow;
    end
  end

  assign backupCellMeasureDone = measureDone_ff;

  // Read-back words
  wire [7:0] maskWord = switchIrqMask_ff & SWITCH_MASK_WMASK;
  logic [7:0] statusWord;
  logic [7:0] controlWord;

  always_comb begin
    statusWord = 8'h00;
    statusWord[ST_SEAL_BIT] = sealBroken;
    statusWord[ST_NVM_BIT] = nvmChanged;
    statusWord[ST_MAINS_BIT] = mainsLow;
    statusWord[ST_BUTTON_BIT] = buttonLow;
    statusWord[ST_SEQ_LSB +: 2] = seqState;
    statusWord[ST_CELL_LSB +: 2] = cellLevel_ff;
  end

  always_comb begin
    controlWord = 8'h00;
    controlWord[CTL_PFSHUT_BIT] = pfShutdownEn_ff;
    controlWord[CTL_GO_BIT] = measureGo_ff;
  end

  // Unmapped subaddresses read as zero
  wire [7:0] rdMux = selMask ? maskWord :
                     selStatus ? statusWord :
                     selControl ? controlWord : 8'h00;
  // Held between reads, so a slow host may fetch it late
  logic [7:0] rdData_ff;
  wire [7:0] nxt_rdData = regRdEn ? rdMux : rdData_ff;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  assign regRdData = rdData_ff;

endmodule

`default_nettype wire

/* File: design/pmic_regs_pkg.sv */
// Package for the mask, status and control register bank.
// Assumes an 8-bit register port with byte subaddresses and a 100 MHz clock.
`default_nettype none

package pmic_regs_pkg;

  // Register subaddresses
  localparam logic [7:0] ADDR_SWITCH_IRQ_MASK = 8'h04;
  localparam logic [7:0] ADDR_CHIP_STATUS = 8'h05;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h06;

  // Reset values
  localparam logic [7:0] RST_SWITCH_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;

  // Switch mask field positions
  localparam int FAULT_MASK_LSB = 3;
  localparam int ILIMIT_MASK_LSB = 0;
  localparam int NUM_SWITCHES = 3;
  localparam logic [7:0] SWITCH_MASK_WMASK = 8'h3f;

  // Status field positions
  localparam int ST_SEAL_BIT = 7;
  localparam int ST_NVM_BIT = 6;
  localparam int ST_MAINS_BIT = 5;
  localparam int ST_BUTTON_BIT = 4;
  localparam int ST_SEQ_LSB = 2;
  localparam int ST_CELL_LSB = 0;

  // Control field positions
  localparam int CTL_GO_BIT = 0;
  localparam int CTL_PFSHUT_BIT = 1;

  // Sequencer state codes reported in status
  localparam logic [1:0] SEQ_TRANSITIONAL = 2'h0;
  localparam logic [1:0] SEQ_WAIT_POWER_EN = 2'h1;
  localparam logic [1:0] SEQ_ACTIVE = 2'h2;
  localparam logic [1:0] SEQ_SUSPEND = 2'h3;

  // Backup cell level codes
  localparam logic [1:0] CELL_ABSENT = 2'h0;
  localparam logic [1:0] CELL_LOW = 2'h1;
  localparam logic [1:0] CELL_GOOD = 2'h2;
  localparam logic [1:0] CELL_IDEAL = 2'h3;

  // Comparator settling time before the level is captured
  localparam int CLK_PERIOD_NS = 10;
  localparam int CELL_SETTLE_NS = 2000;
  localparam int CELL_SETTLE_CYCLES = (CELL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    MEAS_IDLE = 3'b001,
    MEAS_SETTLE = 3'b010,
    MEAS_CAPTURE = 3'b100
  } meas_state_t;

endpackage

`default_nettype wire

/* File: test/host_port_model.sv */
// Host side of the byte register port, one strobe per access.
// Drives at the falling edge; read data is taken a cycle after the read.
`default_nettype none
module host_port_model (
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
    // Released bus shows no stale value
    regWrData = ~d;
    regAddr = ~a;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clk);
    regRdEn = 1'b0;
    regAddr = ~a;
    @(negedge clk);
    d = regRdData;
  endtask
endmodule
`default_nettype wire

/* File: test/pmic_regs_monitor.sv */
// Checker for the mask, status and control register bank.
// Sees only the top ports; mirrors mask and control writes itself.
`default_nettype none
module pmic_regs_monitor
  import pmic_regs_pkg::*;
#(
  parameter int SETTLE_CYCLES = CELL_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic powerfailOutLow_n,
  input wire logic [2:0] swFaultActive,
  input wire logic [2:0] swLimiting,
  input wire logic cellCompEnable,
  input wire logic backupCellMeasureDone,
  input wire logic [2:0] swFaultFlag,
  input wire logic [2:0] swIlimitFlag,
  input wire logic powerfailShutdownReq,
  input wire logic irqOutLow_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] maskCopy_ff;
  logic pfEn_ff;
  int measCnt_ff;
  wire ctlWr = regWrEn && regAddr == ADDR_POWER_CONTROL;
  // Go while busy is dropped, so it must not restart the count
  wire goWr = ctlWr && regWrData[CTL_GO_BIT] && !cellCompEnable;
  wire measRun = measCnt_ff inside {[1:SETTLE_CYCLES + 1]};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maskCopy_ff <= '0;
      pfEn_ff <= 1'b0;
      measCnt_ff <= 0;
    end else begin
      if (regWrEn && regAddr == ADDR_SWITCH_IRQ_MASK) maskCopy_ff <= regWrData[5:0];
      if (ctlWr) pfEn_ff <= regWrData[CTL_PFSHUT_BIT];
      if (goWr) measCnt_ff <= 1;
      else if (backupCellMeasureDone) measCnt_ff <= 0;
      else if (measCnt_ff != 0) measCnt_ff <= measCnt_ff + 1;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence limSteady;
    $stable(swLimiting) [*6];
  endsequence
  sequence faultSteady;
    $stable(swFaultActive) [*6];
  endsequence
  sequence tripHeld;
    (pfEn_ff && !powerfailOutLow_n) [*7];
  endsequence
  irq_pin_level_a: assert property (
    irqOutLow_n == !$past(|({swFaultFlag, swIlimitFlag} & ~maskCopy_ff))) else $error("irq pin wrong");
  meas_done_a: assert property (
    backupCellMeasureDone == (measCnt_ff == SETTLE_CYCLES + 2)) else $error("done pulse timing");
  comp_enable_a: assert property (cellCompEnable == measRun) else $error("comparator enable");
  pf_blocked_a: assert property (!pfEn_ff [*3] |-> !powerfailShutdownReq) else $error("shutdown when off");
  pf_trip_a: assert property (tripHeld |-> powerfailShutdownReq) else $error("no shutdown");
  pf_quiet_a: assert property (powerfailOutLow_n [*7] |-> !powerfailShutdownReq) else $error("no trip");
  ilimit_flag_a: assert property (limSteady |-> swIlimitFlag == swLimiting) else $error("ilimit flag");
  fault_flag_a: assert property (faultSteady |-> swFaultFlag == swFaultActive) else $error("fault flag");
  mask_read_a: assert property (
    regRdEn && !regWrEn && regAddr == ADDR_SWITCH_IRQ_MASK |=> regRdData == {2'h0, maskCopy_ff})
    else $error("mask readback");
endmodule

bind pmic_mask_status_control_regs pmic_regs_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_pmic_regs_monitor (
  .clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .powerfailOutLow_n,
  .swFaultActive, .swLimiting, .cellCompEnable, .backupCellMeasureDone, .swFaultFlag,
  .swIlimitFlag, .powerfailShutdownReq, .irqOutLow_n);
`default_nettype wire

/* File: test/tb_pmic_mask_status_control_regs.sv */
// Self-checking bench for the mask, status and control register bank.
// Pins and comparators are driven here; registers through the host model.
`default_nettype none
module tb_pmic_mask_status_control_regs;
  import pmic_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 4;
  logic clk, rst_n, mainsDetectPin_n, buttonPin_n, powerfailOutLow_n, factorySeal, nvmDefaultsChanged;
  logic cellAboveLow, cellAboveGood, cellAboveIdeal, regWrEn, regRdEn;
  logic cellCompEnable, backupCellMeasureDone, powerfailShutdownReq, irqOutLow_n;
  logic [1:0] seqState;
  logic [2:0] swFaultActive, swLimiting, swFaultFlag, swIlimitFlag;
  logic [7:0] regAddr, regWrData, regRdData;
  int badCount = 0;
  int totalChecks = 0;
  host_port_model i_host_port_model (.clk, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData);
  pmic_mask_status_control_regs #(.SETTLE_CYCLES(SETTLE)) i_pmic_mask_status_control_regs (
    .clk, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .mainsDetectPin_n,
    .buttonPin_n, .powerfailOutLow_n, .factorySeal, .nvmDefaultsChanged, .seqState, .swFaultActive,
    .swLimiting, .cellAboveLow, .cellAboveGood, .cellAboveIdeal, .cellCompEnable,
    .backupCellMeasureDone, .swFaultFlag, .swIlimitFlag, .powerfailShutdownReq, .irqOutLow_n);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic finalReport();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic testMasks();
    logic [7:0] d;
    i_host_port_model.rd(ADDR_POWER_CONTROL, d);
    chk(d, 8'h00, "control reset");
    i_host_port_model.rd(ADDR_SWITCH_IRQ_MASK, d);
    chk(d, 8'h00, "mask reset");
    i_host_port_model.rd(8'h09, d);
    chk(d, 8'h00, "unmapped read");
    for (int i = 0; i < 6; i++) begin
      {swFaultActive, swLimiting} = 6'h01 << i;
      repeat (8) @(negedge clk);
      chk({7'h00, irqOutLow_n}, 8'h00, "unmasked event");
      i_host_port_model.wr(ADDR_SWITCH_IRQ_MASK, 8'h01 << i);
      repeat (2) @(negedge clk);
      chk({7'h00, irqOutLow_n}, 8'h01, "masked event");
      chk({2'h0, swFaultFlag, swIlimitFlag}, 8'h01 << i, "flag under mask");
      i_host_port_model.wr(ADDR_SWITCH_IRQ_MASK, 8'h00);
    end
    {swFaultActive, swLimiting} = 6'h00;
    repeat (8) @(negedge clk);
    chk({7'h00, irqOutLow_n}, 8'h01, "pin release");
    i_host_port_model.wr(ADDR_SWITCH_IRQ_MASK, 8'hff);
    i_host_port_model.rd(ADDR_SWITCH_IRQ_MASK, d);
    chk(d, 8'h3f, "mask bits");
    $display("mask test done");
  endtask
  task automatic testStatus();
    logic [7:0] d;
    // Comparators high: an unmeasured level must still read zero
    {cellAboveIdeal, cellAboveGood, cellAboveLow} = 3'h7;
    i_host_port_model.wr(ADDR_CHIP_STATUS, 8'hff);
    for (int i = 0; i < 4; i++) begin
      {factorySeal, nvmDefaultsChanged} = i[1:0];
      {mainsDetectPin_n, buttonPin_n} = ~i[1:0];
      seqState = i[1:0];
      repeat (8) @(negedge clk);
      i_host_port_model.rd(ADDR_CHIP_STATUS, d);
      chk(d, {i[1:0], i[1:0], i[1:0], 2'h0}, "status fields");
    end
    $display("status test done");
  endtask
  task automatic testMeasure();
    logic [7:0] d;
    int n;
    for (int k = 0; k < 4; k++) begin
      {cellAboveIdeal, cellAboveGood, cellAboveLow} = 3'((1 << k) - 1);
      repeat (8) @(negedge clk);
      i_host_port_model.wr(ADDR_POWER_CONTROL, 8'h01);
      i_host_port_model.rd(ADDR_POWER_CONTROL, d);
      chk(d, 8'h01, "go while busy");
      // Second go lands on the done edge while still busy: refused
      i_host_port_model.wr(ADDR_POWER_CONTROL, 8'h01);
      n = 0;
      while (backupCellMeasureDone !== 1'b1 && n < 50) begin
        @(negedge clk);
        n++;
      end
      if (backupCellMeasureDone !== 1'b1) begin
        chk(8'h00, 8'h01, "measurement timeout");
        finalReport();
      end
      i_host_port_model.rd(ADDR_CHIP_STATUS, d);
      chk({6'h00, d[1:0]}, 8'(k), "cell level");
      i_host_port_model.rd(ADDR_POWER_CONTROL, d);
      chk(d, 8'h00, "go self clear");
    end
    {cellAboveIdeal, cellAboveGood, cellAboveLow} = 3'h0;
    repeat (8) @(negedge clk);
    i_host_port_model.rd(ADDR_CHIP_STATUS, d);
    chk({6'h00, d[1:0]}, 8'h03, "level held");
    $display("measure test done");
  endtask
  task automatic testPowerfail();
    logic [7:0] d;
    powerfailOutLow_n = 1'b0;
    repeat (8) @(negedge clk);
    chk({7'h00, powerfailShutdownReq}, 8'h00, "trip while off");
    i_host_port_model.wr(ADDR_POWER_CONTROL, 8'hfe);
    repeat (4) @(negedge clk);
    chk({7'h00, powerfailShutdownReq}, 8'h01, "trip shutdown");
    i_host_port_model.rd(ADDR_POWER_CONTROL, d);
    chk(d, 8'h02, "control bits");
    i_host_port_model.wr(ADDR_POWER_CONTROL, 8'h00);
    repeat (4) @(negedge clk);
    chk({7'h00, powerfailShutdownReq}, 8'h00, "shutdown off");
    powerfailOutLow_n = 1'b1;
    $display("powerfail test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    {mainsDetectPin_n, buttonPin_n, powerfailOutLow_n} = 3'h7;
    {factorySeal, nvmDefaultsChanged, cellAboveLow, cellAboveGood, cellAboveIdeal} = 5'h00;
    seqState = 2'h0;
    {swFaultActive, swLimiting} = 6'h00;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    testMasks();
    testStatus();
    testMeasure();
    testPowerfail();
    finalReport();
  end
endmodule
`default_nettype wire
